// ---- src/pcf_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcf_cfg.svh"
module pcf_flags #(
  parameter int DATA_W = `PCF_DATA_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Operation strobe and class from the execution unit.
  input wire logic op_valid,
  input wire pcf_pkg::pcf_op_t op_kind,
  input wire pcf_pkg::pcf_rel_t cmp_rel,
  // Operands and results.
  input wire logic [DATA_W-1:0] accumulator_one,
  input wire logic [DATA_W-1:0] accumulator_two,
  input wire logic [`PCF_SUM_W-1:0] arith_result,
  input wire logic shift_last_bit,
  // Flags.
  output logic result_code_bit0,
  output logic result_code_bit1,
  output logic overflow_flag,
  output logic logic_result_bit,
  output logic logic_result_valid,
  // Jump conditions.
  output logic jump_if_zero,
  output logic jump_if_nonzero,
  output logic jump_if_positive,
  output logic jump_if_negative,
  output logic jump_if_overflow
);
  logic [1:0] code_d;
  logic [1:0] code_q;
  logic ovf_d;
  logic ovf_q;
  logic rlo_d;
  logic rlo_q;
  logic rlov_d;
  logic rlov_q;
  logic signed [DATA_W-1:0] acc1_s;
  logic signed [DATA_W-1:0] acc2_s;
  logic signed [`PCF_SUM_W-1:0] sum_s;
  logic lt;
  logic eq;
  pcf_jump_if jbus ();

  assign acc1_s = signed'(accumulator_one);
  assign acc2_s = signed'(accumulator_two);
  assign sum_s = signed'(arith_result);
  assign lt = acc2_s < acc1_s;
  assign eq = accumulator_two == accumulator_one;

  // Next flag values; unlisted operations and idle cycles keep all flags but clear logic_result_valid.
  always_comb begin
    code_d = code_q;
    ovf_d = ovf_q;
    rlo_d = rlo_q;
    rlov_d = 1'b0;
    if (op_valid) begin
      case (op_kind)
        pcf_pkg::PCF_OP_COMPARE: begin
          // Overflow is left alone for comparisons.
          code_d = eq ? `PCF_CODE_ZERO : (lt ? `PCF_CODE_NEG : `PCF_CODE_POS);
          rlov_d = 1'b1;
          case (cmp_rel)
            pcf_pkg::PCF_REL_EQ: rlo_d = eq;
            pcf_pkg::PCF_REL_NE: rlo_d = !eq;
            pcf_pkg::PCF_REL_GT: rlo_d = !eq && !lt;
            pcf_pkg::PCF_REL_LT: rlo_d = lt;
            pcf_pkg::PCF_REL_GE: rlo_d = !lt;
            pcf_pkg::PCF_REL_LE: rlo_d = lt || eq;
            default: rlo_d = 1'b0;
          endcase
        end
        pcf_pkg::PCF_OP_ARITH: begin
          if (arith_result == `PCF_SUM_M65536) begin
            code_d = `PCF_CODE_ZERO;
            ovf_d = 1'b1;
          end else if (sum_s < signed'(`PCF_SUM_MIN)) begin
            code_d = `PCF_CODE_POS;
            ovf_d = 1'b1;
          end else if (sum_s > signed'(`PCF_SUM_MAX)) begin
            code_d = `PCF_CODE_NEG;
            ovf_d = 1'b1;
          end else begin
            ovf_d = 1'b0;
            if (sum_s < 0) code_d = `PCF_CODE_NEG;
            else if (sum_s == 0) code_d = `PCF_CODE_ZERO;
            else code_d = `PCF_CODE_POS;
          end
        end
        pcf_pkg::PCF_OP_LOGIC: begin
          code_d = (accumulator_one == '0) ? `PCF_CODE_ZERO : `PCF_CODE_POS;
        end
        pcf_pkg::PCF_OP_SHIFT: begin
          code_d = shift_last_bit ? `PCF_CODE_POS : `PCF_CODE_ZERO;
        end
        pcf_pkg::PCF_OP_TWOS: begin
          // Accumulator one already holds the converted value.
          ovf_d = (accumulator_one == `PCF_MIN_WORD);
          if (acc1_s < 0) code_d = `PCF_CODE_NEG;
          else if (acc1_s == 0) code_d = `PCF_CODE_ZERO;
          else code_d = `PCF_CODE_POS;
        end
        default: begin
          code_d = code_q;
        end
      endcase
    end
  end

  // Flag registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_q <= `PCF_CODE_ZERO;
      ovf_q <= 1'b0;
      rlo_q <= 1'b0;
      rlov_q <= 1'b0;
    end else begin
      code_q <= code_d;
      ovf_q <= ovf_d;
      rlo_q <= rlo_d;
      rlov_q <= rlov_d;
    end
  end

  assign result_code_bit0 = code_q[0];
  assign result_code_bit1 = code_q[1];
  assign overflow_flag = ovf_q;
  assign logic_result_bit = rlo_q;
  assign logic_result_valid = rlov_q;
  assign jbus.code = code_q;
  assign jbus.ovf = ovf_q;

  // Jump decode lives apart so the sequencer sees it as one registered stage.
  pcf_jump_eval u_jump (
    .core_clk(core_clk),
    .rst(rst),
    .flags(jbus),
    .jump_if_zero(jump_if_zero),
    .jump_if_nonzero(jump_if_nonzero),
    .jump_if_positive(jump_if_positive),
    .jump_if_negative(jump_if_negative),
    .jump_if_overflow(jump_if_overflow)
  );

  sequence s_cmp;
    op_valid && op_kind == pcf_pkg::PCF_OP_COMPARE;
  endsequence

  property p_cmp_code;
    @(posedge core_clk) disable iff (rst)
      s_cmp |=> {result_code_bit1, result_code_bit0} ==
        ($past(accumulator_two == accumulator_one) ? 2'h0 :
          ($past($signed(accumulator_two) < $signed(accumulator_one)) ? 2'h1 : 2'h2));
  endproperty
  a_cmp_code: assert property (p_cmp_code) else $error("compare code wrong");

  property p_cmp_ovf;
    @(posedge core_clk) disable iff (rst)
      s_cmp |=> $stable(overflow_flag);
  endproperty
  a_cmp_ovf: assert property (p_cmp_ovf) else $error("compare changed overflow");

  property p_cmp_eq_rlo;
    @(posedge core_clk) disable iff (rst)
      s_cmp ##0 (cmp_rel == pcf_pkg::PCF_REL_EQ)
        |=> logic_result_bit == $past(accumulator_two == accumulator_one);
  endproperty
  a_cmp_eq_rlo: assert property (p_cmp_eq_rlo) else $error("compare result bit wrong");

  property p_arith_zero;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_ARITH && arith_result == 18'h00000
        |=> !overflow_flag && !result_code_bit0 && !result_code_bit1 ##1 !jump_if_overflow;
  endproperty
  a_arith_zero: assert property (p_arith_zero) else $error("arith zero flags wrong");

  property p_arith_m65536;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_ARITH && arith_result == `PCF_SUM_M65536
        |=> overflow_flag && {result_code_bit1, result_code_bit0} == 2'h0 ##1 jump_if_zero;
  endproperty
  a_arith_m65536: assert property (p_arith_m65536) else $error("arith wrap flags wrong");

  property p_logic_code;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_LOGIC && accumulator_one != 16'h0000
        |=> result_code_bit1 && !result_code_bit0 && $stable(overflow_flag);
  endproperty
  a_logic_code: assert property (p_logic_code) else $error("logic code wrong");

  property p_shift_code;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_SHIFT
        |=> result_code_bit1 == $past(shift_last_bit) && !result_code_bit0;
  endproperty
  a_shift_code: assert property (p_shift_code) else $error("shift code wrong");

  property p_twos_min;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_TWOS && accumulator_one == 16'h8000
        |=> overflow_flag && result_code_bit0 && !result_code_bit1;
  endproperty
  a_twos_min: assert property (p_twos_min) else $error("twos min flags wrong");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      !op_valid |=> $stable({result_code_bit1, result_code_bit0, overflow_flag});
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed while idle");

  property p_none_hold;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_NONE
        |=> $stable({result_code_bit1, result_code_bit0, overflow_flag});
  endproperty
  a_none_hold: assert property (p_none_hold) else $error("flags changed on no-flag op");

  property p_cmp_valid;
    @(posedge core_clk) disable iff (rst)
      s_cmp |=> logic_result_valid;
  endproperty
  a_cmp_valid: assert property (p_cmp_valid) else $error("compare valid pulse missing");

  property p_cmp_lt_rlo;
    @(posedge core_clk) disable iff (rst)
      s_cmp ##0 (cmp_rel == pcf_pkg::PCF_REL_LT)
        |=> logic_result_bit == $past($signed(accumulator_two) < $signed(accumulator_one));
  endproperty
  a_cmp_lt_rlo: assert property (p_cmp_lt_rlo) else $error("compare lt bit wrong");

  // In-range negative sums fill the top of the 18-bit code space, so an unsigned test suffices.
  sequence s_arith_neg;
    op_valid && op_kind == pcf_pkg::PCF_OP_ARITH && arith_result >= `PCF_SUM_MIN;
  endsequence

  sequence s_neg_flags;
    !overflow_flag && result_code_bit0 && !result_code_bit1 ##1 jump_if_negative;
  endsequence

  property p_arith_neg;
    @(posedge core_clk) disable iff (rst)
      s_arith_neg |=> s_neg_flags;
  endproperty
  a_arith_neg: assert property (p_arith_neg) else $error("arith negative flags wrong");

  // Sums past the positive limit but still clear of the sign bit of the wide result.
  sequence s_arith_above;
    op_valid && op_kind == pcf_pkg::PCF_OP_ARITH && !arith_result[`PCF_SUM_W-1] &&
      arith_result > `PCF_SUM_MAX;
  endsequence

  sequence s_above_flags;
    overflow_flag && result_code_bit0 && !result_code_bit1 ##1 jump_if_overflow;
  endsequence

  property p_arith_above;
    @(posedge core_clk) disable iff (rst)
      s_arith_above |=> s_above_flags;
  endproperty
  a_arith_above: assert property (p_arith_above) else $error("arith high overflow wrong");

  property p_arith_below;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_ARITH && arith_result[`PCF_SUM_W-1] &&
        arith_result < `PCF_SUM_MIN && arith_result != `PCF_SUM_M65536
        |=> overflow_flag && result_code_bit1 && !result_code_bit0;
  endproperty
  a_arith_below: assert property (p_arith_below) else $error("arith low overflow wrong");

  property p_logic_zero;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_LOGIC && accumulator_one == 16'h0000
        |=> !result_code_bit1 && !result_code_bit0 && $stable(overflow_flag);
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("logic zero code wrong");

  property p_twos_other;
    @(posedge core_clk) disable iff (rst)
      op_valid && op_kind == pcf_pkg::PCF_OP_TWOS && accumulator_one != 16'h8000
        |=> !overflow_flag;
  endproperty
  a_twos_other: assert property (p_twos_other) else $error("twos overflow set wrongly");
endmodule : pcf_flags
`default_nettype wire

// ---- src/pcf_cfg.svh ----
// Contract
// - Compare two against one: code 00 equal, 01 less, 10 greater.
// - Comparisons leave the overflow flag unchanged.
// - Comparison writes logic result bit 1 when the relation holds.
// - In-range arithmetic clears overflow; code 01 negative, 00 zero, 10 positive.
// - Overflow sets flag; below range code 10, above 01, minus 65536 gives 00.
// - Word logic: code 00 when accumulator zero, else 10; overflow kept.
// - Shift: code follows last bit out, 00 for 0, 10 for 1; overflow kept.
// - Twos complement updates code and overflow; 8000 gives 01 with overflow set.
// - Jumps: zero on 00, nonzero 01/10, positive 10, negative 01, overflow on flag.
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH
`define PCF_DATA_W 16
`define PCF_SUM_W 18
`define PCF_CODE_ZERO 2'h0
`define PCF_CODE_NEG 2'h1
`define PCF_CODE_POS 2'h2
`define PCF_MIN_WORD 16'h8000
`define PCF_SUM_MIN 18'h38000
`define PCF_SUM_MAX 18'h07FFF
`define PCF_SUM_M65536 18'h30000
`endif

// ---- src/pcf_pkg.sv ----
`default_nettype none
package pcf_pkg;
  // Operation classes presented by the instruction execution unit.
  typedef enum logic [2:0] {
    PCF_OP_NONE,
    PCF_OP_COMPARE,
    PCF_OP_ARITH,
    PCF_OP_LOGIC,
    PCF_OP_SHIFT,
    PCF_OP_TWOS
  } pcf_op_t;

  // Comparison relations whose truth goes to the logic result bit.
  typedef enum logic [2:0] {
    PCF_REL_EQ,
    PCF_REL_NE,
    PCF_REL_GT,
    PCF_REL_LT,
    PCF_REL_GE,
    PCF_REL_LE
  } pcf_rel_t;
endpackage : pcf_pkg
`default_nettype wire

// ---- src/pcf_jump_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries the registered flags from the flag core to the jump decoder.
interface pcf_jump_if;
  logic [1:0] code;
  logic ovf;
  modport core (output code, output ovf);
  modport jump (input code, input ovf);
endinterface : pcf_jump_if
`default_nettype wire

// ---- src/pcf_jump_eval.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcf_cfg.svh"
module pcf_jump_eval (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Flags from the core.
  pcf_jump_if.jump flags,
  // Registered jump conditions.
  output logic jump_if_zero,
  output logic jump_if_nonzero,
  output logic jump_if_positive,
  output logic jump_if_negative,
  output logic jump_if_overflow
);
  logic [4:0] cond_d;
  logic [4:0] cond_q;

  // Decode the jump conditions from the current flags.
  always_comb begin
    cond_d[0] = (flags.code == `PCF_CODE_ZERO);
    cond_d[1] = (flags.code == `PCF_CODE_NEG) || (flags.code == `PCF_CODE_POS);
    cond_d[2] = (flags.code == `PCF_CODE_POS);
    cond_d[3] = (flags.code == `PCF_CODE_NEG);
    cond_d[4] = flags.ovf;
  end

  // Registered so every output leaves a flip-flop; conditions lag the flags by one cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cond_q <= 5'h01;
    end else begin
      cond_q <= cond_d;
    end
  end

  assign jump_if_zero = cond_q[0];
  assign jump_if_nonzero = cond_q[1];
  assign jump_if_positive = cond_q[2];
  assign jump_if_negative = cond_q[3];
  assign jump_if_overflow = cond_q[4];

  property p_jump_zero;
    @(posedge core_clk) disable iff (rst)
      (flags.code == `PCF_CODE_ZERO) |=> jump_if_zero && !jump_if_nonzero;
  endproperty
  a_jump_zero: assert property (p_jump_zero) else $error("zero jump decode wrong");

  property p_jump_sign;
    @(posedge core_clk) disable iff (rst)
      (flags.code == `PCF_CODE_NEG) |=> jump_if_negative && !jump_if_positive && jump_if_nonzero;
  endproperty
  a_jump_sign: assert property (p_jump_sign) else $error("negative jump decode wrong");

  property p_jump_pos;
    @(posedge core_clk) disable iff (rst)
      (flags.code == `PCF_CODE_POS) |=> jump_if_positive && jump_if_nonzero && !jump_if_zero;
  endproperty
  a_jump_pos: assert property (p_jump_pos) else $error("positive jump decode wrong");

  property p_jump_ovf;
    @(posedge core_clk) disable iff (rst)
      flags.ovf |=> jump_if_overflow;
  endproperty
  a_jump_ovf: assert property (p_jump_ovf) else $error("overflow jump decode wrong");
endmodule : pcf_jump_eval
`default_nettype wire

// ---- tb/pcf_jump_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcf_jump_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Flags as the jump logic sees them.
  input wire logic [1:0] code,
  input wire logic ovf,
  // Expected {zero, nonzero, positive, negative, overflow}.
  output logic [4:0] jumps
);
  // Registered, so a jump always acts on the flags of the previous cycle.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      jumps <= 5'h10;
    end else begin
      jumps <= {code == 2'h0, (code == 2'h1) || (code == 2'h2), code == 2'h2, code == 2'h1, ovf};
    end
  end
endmodule : pcf_jump_model
`default_nettype wire

// ---- tb/plc_alu_condition_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module plc_alu_condition_flags_tb;
  localparam logic [17:0] EDGE [8] = '{18'h30000, 18'h37FFF, 18'h38000, 18'h3FFFF,
                                       18'h00000, 18'h00001, 18'h07FFF, 18'h08000};
  logic core_clk, rst, op_valid, shift_last_bit, code1, code0, ovf, lrb, lrb_val;
  pcf_pkg::pcf_op_t op_kind;
  pcf_pkg::pcf_rel_t cmp_rel;
  logic [15:0] acc_one, acc_two;
  logic [17:0] arith_result;
  wire logic [4:0] jmp;
  logic [4:0] jmp_exp, e_jmp;
  logic [31:0] seed, t;
  int bad_count, checks, e_code, e_ovf, e_lrb, e_val, a, b, r;

  pcf_flags i_dut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
    .cmp_rel(cmp_rel), .accumulator_one(acc_one), .accumulator_two(acc_two),
    .arith_result(arith_result), .shift_last_bit(shift_last_bit), .result_code_bit0(code0),
    .result_code_bit1(code1), .overflow_flag(ovf), .logic_result_bit(lrb),
    .logic_result_valid(lrb_val), .jump_if_zero(jmp[4]), .jump_if_nonzero(jmp[3]),
    .jump_if_positive(jmp[2]), .jump_if_negative(jmp[1]), .jump_if_overflow(jmp[0]));

  pcf_jump_model i_jump (.core_clk(core_clk), .rst(rst), .code({code1, code0}), .ovf(ovf),
    .jumps(jmp_exp));

  // Free-running clock of 20 ns.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Operands lean on boundary values, where a flag decision is easiest to get wrong.
  function automatic logic [15:0] pick(input logic [31:0] v);
    case (v[2:0])
      3'h0: return 16'h0000;
      3'h1: return 16'h8000;
      3'h2: return 16'h7FFF;
      3'h3: return 16'hFFFF;
      default: return v[31:16];
    endcase
  endfunction : pick

  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Reference flags, updated at the same edge that takes an operation.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      e_code = 0;
      e_ovf = 0;
      e_lrb = 0;
      e_val = 0;
      e_jmp = 5'h10;
    end else begin
      // Jumps act on the flags left by the previous edge.
      e_jmp = {e_code == 0, e_code inside {1, 2}, e_code == 2, e_code == 1, e_ovf[0]};
      e_val = 0;
      a = int'($signed(acc_one));
      b = int'($signed(acc_two));
      r = int'($signed(arith_result));
      if (op_valid) begin
        case (op_kind)
          pcf_pkg::PCF_OP_COMPARE: begin
            e_code = (b == a) ? 0 : (b < a) ? 1 : 2;
            e_val = 1;
            case (cmp_rel)
              pcf_pkg::PCF_REL_EQ: e_lrb = int'(b == a);
              pcf_pkg::PCF_REL_NE: e_lrb = int'(b != a);
              pcf_pkg::PCF_REL_GT: e_lrb = int'(b > a);
              pcf_pkg::PCF_REL_LT: e_lrb = int'(b < a);
              pcf_pkg::PCF_REL_GE: e_lrb = int'(b >= a);
              default: e_lrb = int'(b <= a);
            endcase
          end
          pcf_pkg::PCF_OP_ARITH: begin
            e_ovf = int'(r < -32768 || r > 32767);
            if (r == -65536 || r == 0) e_code = 0;
            else if (r < -32768) e_code = 2;
            else if (r > 32767) e_code = 1;
            else e_code = (r < 0) ? 1 : 2;
          end
          pcf_pkg::PCF_OP_LOGIC: e_code = (acc_one == 16'h0000) ? 0 : 2;
          pcf_pkg::PCF_OP_SHIFT: e_code = shift_last_bit ? 2 : 0;
          pcf_pkg::PCF_OP_TWOS: begin
            e_ovf = int'(acc_one == 16'h8000);
            e_code = (a < 0) ? 1 : (a == 0) ? 0 : 2;
          end
          default: ;
        endcase
      end
    end
  end

  // Every settled cycle is compared, so back-to-back and idle cycles are both covered.
  always @(negedge core_clk) begin
    if (!rst) begin
      chk({3'h0, code1, code0}, {3'h0, e_code[1:0]});
      chk({4'h0, ovf}, {4'h0, e_ovf[0]});
      chk({3'h0, lrb, lrb_val}, {3'h0, e_lrb[0], e_val[0]});
      chk(jmp, jmp_exp);
      chk(jmp, e_jmp);
    end
  end

  // Random stream of operations, with a second reset in mid-run.
  initial begin
    seed = 32'h00006EAF;
    bad_count = 0;
    checks = 0;
    {op_valid, shift_last_bit, acc_one, acc_two, arith_result} = '0;
    op_kind = pcf_pkg::PCF_OP_NONE;
    cmp_rel = pcf_pkg::PCF_REL_EQ;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge core_clk);
      t = xs();
      op_kind = pcf_pkg::pcf_op_t'(t[10:8] % 3'h6);
      cmp_rel = pcf_pkg::pcf_rel_t'(t[13:11] % 3'h6);
      shift_last_bit = t[14];
      acc_one = pick(xs());
      acc_two = t[15] ? acc_one : pick(xs());
      arith_result = t[3] ? EDGE[t[6:4]] : 18'(xs());
      if (i == 2000) rst = 1'b1;
      if (i == 2002) rst = 1'b0;
      op_valid = (t[1:0] != 2'h0) && !rst;
    end
    complete_run();
  end
endmodule : plc_alu_condition_flags_tb
`default_nettype wire
